// >>> hw/spc_pkg.sv
// Package: register map, field positions, opcodes, timing and carrier types
package spc_pkg;
  // Register offsets
  localparam logic [3:0] A_CNT_LO = 4'h0;
  localparam logic [3:0] A_CNT_HI = 4'h1;
  localparam logic [3:0] A_QUEUE = 4'h2;
  localparam logic [3:0] A_CMD = 4'h3;
  localparam logic [3:0] A_STAT = 4'h4;
  localparam logic [3:0] A_IRQ = 4'h5;
  localparam logic [3:0] A_SEQ = 4'h6;
  localparam logic [3:0] A_FLAGS = 4'h7;
  localparam logic [3:0] A_SETUP1 = 4'h8;
  localparam logic [3:0] A_CLKDIV = 4'h9;
  localparam logic [3:0] A_TEST = 4'ha;
  localparam logic [3:0] A_SETUP2 = 4'hb;
  localparam logic [3:0] A_SETUP3 = 4'hc;
  localparam logic [3:0] A_RSVBYTE = 4'hf;
  // Interrupt cause bits
  localparam int IR_SEL = 0;
  localparam int IR_SELATN = 1;
  localparam int IR_RESEL = 2;
  localparam int IR_FDONE = 3;
  localparam int IR_BSERV = 4;
  localparam int IR_DISC = 5;
  localparam int IR_ILLEGAL = 6;
  localparam int IR_BUSRST = 7;
  // First setup register bits (own ID sits in 2:0)
  localparam int S1_TEST = 3;
  localparam int S1_PAR = 4;
  localparam int S1_PTEST = 5;
  localparam int S1_RSTDIS = 6;
  localparam int S1_SLOW = 7;
  // Test register bits
  localparam int T_TGT = 0;
  localparam int T_INI = 1;
  localparam int T_TRI = 2;
  // Second setup register: reserve byte enable
  localparam int S2_RSV = 7;
  // Opcodes with the DMA bit stripped
  localparam logic [6:0] OP_NOP = 7'h00;
  localparam logic [6:0] OP_FLUSH = 7'h01;
  localparam logic [6:0] OP_CHIPRST = 7'h02;
  localparam logic [6:0] OP_BUSRST = 7'h03;
  localparam logic [6:0] OP_ABORT = 7'h06;
  localparam logic [6:0] OP_XFER = 7'h10;
  localparam logic [6:0] OP_ICC = 7'h11;
  localparam logic [6:0] OP_MSGOK = 7'h12;
  localparam logic [6:0] OP_PAD = 7'h18;
  localparam logic [6:0] OP_SETATN = 7'h1a;
  localparam logic [6:0] OP_TSEND_LO = 7'h20;
  localparam logic [6:0] OP_TSEND_HI = 7'h22;
  localparam logic [6:0] OP_TSEQ_HI = 7'h25;
  localparam logic [6:0] OP_TDISC = 7'h27;
  localparam logic [6:0] OP_TRECV_LO = 7'h28;
  localparam logic [6:0] OP_TRECV_HI = 7'h2b;
  localparam logic [6:0] OP_DISC_LO = 7'h40;
  localparam logic [6:0] OP_DISC_HI = 7'h46;
  localparam logic [2:0] SEQ_DONE = 3'h4;
  // Timing
  localparam int CLK_NS = 10;
  localparam int SETUP_NS = 55;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLOW_NS = 40;
  localparam int SLOW_CYC = (SLOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSRST_NS = 25000;
  localparam int BUSRST_CYC = BUSRST_NS / CLK_NS;
  localparam int QUEUE_DEPTH = 8;
  // Processor port pins
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [3:0] addr;
    logic [7:0] data;
  } spc_host_t;
  // SCSI bus input pins
  typedef struct packed {
    logic request_in_n;
    logic acknowledge_in_n;
    logic io;
    logic cd;
    logic msg;
    logic rst_n;
    logic par;
    logic [7:0] data;
  } spc_bus_in_t;
  // Handshake progress
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b011,
    ST_WAITREL = 3'b010,
    ST_BUSRST = 3'b110
  } spc_fsm_t;
endpackage

// >>> hw/spc_core.sv
// Protocol controller register bank, command decoder, handshake engine and data queue

// Byte queue with valid/ready on both sides
module spc_queue #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  output logic [$clog2(D):0] level
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } spc_q_t;
  spc_q_t s, n;
  logic push, pop;

  assign in_ready = (s.cnt != D[AW:0]);
  assign out_valid = (s.cnt != '0);
  assign out_data = s.mem[s.rp];
  assign level = s.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and level update; flush drops everything held
  always_comb begin
    n = s;
    if (push) begin
      n.mem[s.wp] = in_data;
      n.wp = s.wp + 1'b1;
    end
    if (pop) begin
      n.rp = s.rp + 1'b1;
    end
    n.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (flush) begin
      n.wp = '0;
      n.rp = '0;
      n.cnt = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) s <= '0;
    else s <= n;
  end
endmodule // spc_queue

module spc_core (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // Processor port
  input wire spc_pkg::spc_host_t HOST_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  output logic INT_N,
  // SCSI bus
  input wire spc_pkg::spc_bus_in_t BUS_IN,
  output logic [7:0] BUS_DATA_OUT,
  output logic BUS_PARITY_OUT,
  output logic BUS_DATA_OE,
  output logic REQUEST_OUT_N,
  output logic ACKNOWLEDGE_OUT_N,
  output logic ATTENTION_OUT_N,
  output logic BUS_RESET_OUT,
  output logic BUS_CTRL_OE
);
  import spc_pkg::*;

  typedef struct packed {
    spc_host_t hs1;
    spc_host_t hs2;
    logic hcs_p;
    logic hrd_p;
    logic hwr_p;
    spc_bus_in_t bs1;
    spc_bus_in_t bs2;
    logic brst_p;
    logic [15:0] cnt_load;
    logic [15:0] cnt;
    logic [7:0] cmd;
    logic xdone;
    logic zero;
    logic perr;
    logic gerr;
    logic [7:0] irq;
    logic [2:0] seq;
    logic [7:0] dest_id;
    logic [7:0] sel_to;
    logic [7:0] speriod;
    logic [7:0] soffset;
    logic [7:0] setup1;
    logic [7:0] clkdiv;
    logic [7:0] test;
    logic [7:0] setup2;
    logic [7:0] setup3;
    logic [7:0] rsv;
    logic sel_en;
    spc_fsm_t fsm;
    logic [11:0] tmr;
    logic xfer;
    logic send;
    logic tgt;
    logic pad;
    logic ph;
    logic req_n;
    logic ack_n;
    logic atn_n;
    logic int_n;
    logic rst_o;
    logic [7:0] bdata;
    logic bpar;
    logic bdoe;
    logic boe;
    logic ctrl_oe;
    logic [7:0] hdata;
    logic hoe;
  } spc_st_t;

  function automatic spc_st_t rst_val();
    rst_val = '0;
    rst_val.hs1 = '1;
    rst_val.hs2 = '1;
    rst_val.hcs_p = 1'b1;
    rst_val.hrd_p = 1'b1;
    rst_val.hwr_p = 1'b1;
    rst_val.bs1 = '1;
    rst_val.bs2 = '1;
    rst_val.brst_p = 1'b1;
    rst_val.req_n = 1'b1;
    rst_val.ack_n = 1'b1;
    rst_val.atn_n = 1'b1;
    rst_val.int_n = 1'b1;
    rst_val.ctrl_oe = 1'b1;
  endfunction

  localparam spc_st_t ST_RST = rst_val();
  localparam logic [11:0] SETUP_T = 12'(SETUP_CYC);
  localparam logic [11:0] SLOW_T = 12'(SLOW_CYC);
  localparam logic [11:0] BUSRST_T = 12'(BUSRST_CYC);

  spc_st_t s, n;
  logic q_in_valid, q_in_ready, q_out_valid, q_out_ready, q_flush;
  logic [7:0] q_in_data, q_out_data;
  logic [3:0] q_level;
  logic wr_evt, rd_evt, peer_on, ready, byte_done, capture, strobe;
  logic [6:0] op;
  logic [7:0] rdata, sbyte;

  spc_queue #(.W(8), .D(QUEUE_DEPTH)) u_queue (
    .clk(MCLK),
    .rst_n(RESETN),
    .flush(q_flush),
    .in_valid(q_in_valid),
    .in_data(q_in_data),
    .in_ready(q_in_ready),
    .out_valid(q_out_valid),
    .out_data(q_out_data),
    .out_ready(q_out_ready),
    .level(q_level)
  );

  // Outputs come straight from the state register
  assign DATA_OUT = s.hdata;
  assign DATA_OE = s.hoe;
  assign INT_N = s.int_n;
  assign BUS_DATA_OUT = s.bdata;
  assign BUS_PARITY_OUT = s.bpar;
  assign BUS_DATA_OE = s.boe;
  assign REQUEST_OUT_N = s.req_n;
  assign ACKNOWLEDGE_OUT_N = s.ack_n;
  assign ATTENTION_OUT_N = s.atn_n;
  assign BUS_RESET_OUT = s.rst_o;
  assign BUS_CTRL_OE = s.ctrl_oe;

  // Read data mux; unlisted and reserved addresses read zero
  always_comb begin
    case (s.hs2.addr)
      A_CNT_LO: rdata = s.cnt[7:0];
      A_CNT_HI: rdata = s.cnt[15:8];
      A_QUEUE: rdata = (!q_out_valid && s.setup2[S2_RSV]) ? s.rsv : q_out_data;
      A_CMD: rdata = s.cmd;
      A_STAT: rdata = {~s.int_n, s.gerr, s.perr, s.zero, s.xdone,
                       ~s.bs2.msg, ~s.bs2.cd, ~s.bs2.io};
      A_IRQ: rdata = s.irq;
      A_SEQ: rdata = {5'h00, s.seq};
      A_FLAGS: rdata = {s.seq, 1'b0, q_level};
      A_SETUP1: rdata = s.setup1;
      A_SETUP2: rdata = s.setup2;
      A_SETUP3: rdata = s.setup3;
      default: rdata = 8'h00;
    endcase
  end

  // Host strobes are resynchronised; act on the edge seen after the second stage
  assign wr_evt = s.hs2.wr_n && !s.hwr_p && !s.hcs_p;
  assign rd_evt = !s.hs2.rd_n && s.hrd_p && !s.hs2.cs_n;
  assign op = s.hs2.data[6:0];
  // Peer strobe: a target watches acknowledge, an initiator watches request
  assign peer_on = s.tgt ? !s.bs2.acknowledge_in_n : !s.bs2.request_in_n;
  assign ready = s.send ? (s.pad || q_out_valid) : q_in_ready;
  assign sbyte = s.pad ? 8'h00 : q_out_data;

  // Queue feed: bus receive wins; host port only used outside transfers
  always_comb begin
    q_in_valid = 1'b0;
    q_in_data = s.bs2.data;
    q_out_ready = 1'b0;
    q_flush = 1'b0;
    if (capture && !s.pad) begin
      q_in_valid = 1'b1;
    end else if (wr_evt && s.hs2.addr == A_QUEUE && !s.xfer) begin
      q_in_valid = 1'b1;
      q_in_data = s.hs2.data;
    end
    if (byte_done && s.send && !s.pad) begin
      q_out_ready = 1'b1;
    end else if (rd_evt && s.hs2.addr == A_QUEUE && !s.xfer) begin
      q_out_ready = 1'b1;
    end
    // Chip reset empties the queue too, so no stale byte survives it
    if (wr_evt && s.hs2.addr == A_CMD && (op == OP_FLUSH || op == OP_CHIPRST)) begin
      q_flush = 1'b1;
    end
  end

  // Register bank, command decode and handshake engine
  always_comb begin
    n = s;
    capture = 1'b0;
    byte_done = 1'b0;
    strobe = s.tgt ? !s.req_n : !s.ack_n;
    n.hs1 = HOST_IN;
    n.hs2 = s.hs1;
    n.hcs_p = s.hs2.cs_n;
    n.hrd_p = s.hs2.rd_n;
    n.hwr_p = s.hs2.wr_n;
    n.bs1 = BUS_IN;
    n.bs2 = s.bs1;
    n.brst_p = s.bs2.rst_n;
    // Reading the causes clears them; any event below still lands
    if (rd_evt) begin
      n.hdata = rdata;
      n.hoe = 1'b1;
      if (s.hs2.addr == A_IRQ) begin
        n.irq = 8'h00;
        n.seq = 3'h0;
        n.perr = 1'b0;
        n.gerr = 1'b0;
      end
    end else if (s.hs2.rd_n || s.hs2.cs_n) begin
      n.hoe = 1'b0;
    end
    if (wr_evt) begin
      case (s.hs2.addr)
        A_CNT_LO: n.cnt_load[7:0] = s.hs2.data;
        A_CNT_HI: n.cnt_load[15:8] = s.hs2.data;
        A_QUEUE: n.gerr = s.gerr || !q_in_ready || s.xfer;
        A_STAT: n.dest_id = s.hs2.data;
        A_IRQ: n.sel_to = s.hs2.data;
        A_SEQ: n.speriod = s.hs2.data;
        A_FLAGS: n.soffset = s.hs2.data;
        A_SETUP1: n.setup1 = s.hs2.data;
        A_CLKDIV: n.clkdiv = s.hs2.data;
        A_TEST: if (s.setup1[S1_TEST]) n.test = s.hs2.data;
        A_SETUP2: n.setup2 = s.hs2.data;
        A_SETUP3: n.setup3 = s.hs2.data;
        A_RSVBYTE: n.rsv = s.hs2.data;
        A_CMD: begin
          n.cmd = s.hs2.data;
          // Opcodes that start a transfer reload the counter
          if (s.xfer && op != OP_ABORT && op != OP_CHIPRST) begin
            n.gerr = 1'b1;
          end else if (op == OP_NOP || op == OP_FLUSH) begin
            n.cmd = s.hs2.data;
          end else if (op == OP_CHIPRST) begin
            n = ST_RST;
          end else if (op == OP_BUSRST) begin
            n.fsm = ST_BUSRST;
            n.tmr = BUSRST_T;
            n.rst_o = 1'b1;
          end else if (op == OP_ABORT) begin
            n.xfer = 1'b0;
            n.fsm = ST_IDLE;
            n.irq[IR_FDONE] = 1'b1;
          end else if (op == OP_XFER || op == OP_PAD) begin
            n.xfer = 1'b1;
            n.pad = (op == OP_PAD);
            n.tgt = s.test[T_TGT];
            n.send = s.bs2.io; // I/O released high: data leaves toward the peer
            n.cnt = s.cnt_load;
            n.xdone = 1'b0;
            n.zero = 1'b0;
          end else if (op == OP_ICC || op == OP_MSGOK) begin
            n.irq[IR_FDONE] = 1'b1;
            if (op == OP_MSGOK) n.atn_n = 1'b1;
          end else if (op == OP_SETATN) begin
            n.atn_n = 1'b0;
          end else if ((op >= OP_TSEND_LO && op <= OP_TSEND_HI) ||
                       (op >= OP_TRECV_LO && op <= OP_TRECV_HI)) begin
            n.xfer = 1'b1;
            n.pad = 1'b0;
            n.tgt = !s.test[T_INI];
            n.send = (op <= OP_TSEND_HI);
            n.cnt = s.cnt_load;
            n.xdone = 1'b0;
            n.zero = 1'b0;
          end else if ((op > OP_TSEND_HI && op <= OP_TSEQ_HI) || op == OP_TDISC) begin
            n.irq[IR_FDONE] = 1'b1;
            n.seq = SEQ_DONE;
          end else if (op >= OP_DISC_LO && op <= OP_DISC_HI) begin
            n.irq[IR_FDONE] = 1'b1;
            n.seq = SEQ_DONE;
            if (op == OP_DISC_LO + 7'h04) n.sel_en = 1'b1;
            if (op == OP_DISC_LO + 7'h05) n.sel_en = 1'b0;
          end else begin
            n.irq[IR_ILLEGAL] = 1'b1;
          end
        end
        default: n.cmd = s.cmd;
      endcase
    end
    // Handshake engine
    case (s.fsm)
      ST_IDLE: begin
        if (s.xfer && s.send && s.soffset != 8'h00) begin
          // Synchronous: data and strobe on the rising phase, release on falling
          n.ph = !s.ph;
          if (!s.ph && ready) begin
            n.bdata = sbyte;
            n.bpar = ~^sbyte ^ s.setup1[S1_PTEST];
            n.bdoe = 1'b1;
            if (s.tgt) n.req_n = 1'b0;
            else n.ack_n = 1'b0;
          end else if (s.ph && strobe) begin
            n.req_n = 1'b1;
            n.ack_n = 1'b1;
            byte_done = 1'b1;
          end
        end else if (s.xfer && ready && (s.tgt ? !peer_on : peer_on)) begin
          if (s.send) begin
            n.bdata = sbyte;
            n.bpar = ~^sbyte ^ s.setup1[S1_PTEST];
            n.bdoe = 1'b1;
            n.tmr = s.setup1[S1_SLOW] ? SETUP_T + SLOW_T : SETUP_T;
            n.fsm = ST_SETUP;
          end else begin
            capture = !s.tgt;
            if (s.tgt) n.req_n = 1'b0;
            else n.ack_n = 1'b0;
            n.fsm = ST_STROBE;
          end
        end
      end
      ST_SETUP: begin
        // Data already on the bus; strobe only after the setup time
        if (s.tmr <= 12'h001) begin
          if (s.tgt) n.req_n = 1'b0;
          else n.ack_n = 1'b0;
          n.fsm = ST_STROBE;
        end else begin
          n.tmr = s.tmr - 12'h001;
        end
      end
      ST_STROBE: begin
        if (s.tgt && peer_on) begin
          capture = !s.send;
          n.req_n = 1'b1;
          byte_done = 1'b1;
          n.fsm = ST_WAITREL;
        end else if (!s.tgt && !peer_on) begin
          n.ack_n = 1'b1;
          byte_done = 1'b1;
          n.fsm = ST_IDLE;
        end
      end
      ST_WAITREL: begin
        // Next request goes out only once acknowledge has risen
        if (!peer_on) n.fsm = ST_IDLE;
      end
      ST_BUSRST: begin
        if (s.tmr <= 12'h001) begin
          n.rst_o = 1'b0;
          n.fsm = ST_IDLE;
        end else begin
          n.tmr = s.tmr - 12'h001;
        end
      end
      default: n.fsm = ST_IDLE;
    endcase
    // Received parity is odd across data and parity bit
    if (capture && s.setup1[S1_PAR] && !(^{s.bs2.data, s.bs2.par})) begin
      n.perr = 1'b1;
    end
    if (byte_done) begin
      n.cnt = s.cnt - 16'h0001;
      if (s.cnt == 16'h0001) begin
        n.zero = 1'b1;
        n.xdone = 1'b1;
        n.xfer = 1'b0;
        n.irq[IR_BSERV] = 1'b1;
      end
    end
    if (!n.xfer) n.bdoe = 1'b0;
    // Falling edge of the bus reset line raises a cause unless muted
    if (!s.bs2.rst_n && s.brst_p && !s.setup1[S1_RSTDIS]) begin
      n.irq[IR_BUSRST] = 1'b1;
    end
    n.int_n = !(|n.irq);
    n.boe = n.bdoe && !n.test[T_TRI];
    n.ctrl_oe = !n.test[T_TRI];
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) s <= ST_RST;
    else s <= n;
  end
endmodule // spc_core

// >>> sim/spc_core_properties.sv
// Concurrent checks on the protocol controller's processor and bus ports
module spc_core_properties (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // Processor port
  input wire spc_pkg::spc_host_t HOST_IN,
  input wire logic DATA_OE,
  // SCSI bus
  input wire spc_pkg::spc_bus_in_t BUS_IN,
  input wire logic [7:0] BUS_DATA_OUT,
  input wire logic BUS_DATA_OE,
  input wire logic REQUEST_OUT_N,
  input wire logic ACKNOWLEDGE_OUT_N,
  input wire logic BUS_RESET_OUT
);
  import spc_pkg::*;
  int rst_len_q;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);

  // Length of the running bus reset pulse; a counter, since 2500 is far past any repetition
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_len_q <= 0;
    end else begin
      rst_len_q <= BUS_RESET_OUT ? rst_len_q + 1 : 0;
    end
  end

  // Host strobe held through the synchroniser and the output register
  sequence s_read_low;
    (!HOST_IN.cs_n && !HOST_IN.rd_n) [*4];
  endsequence
  sequence s_read_off;
    (HOST_IN.cs_n || HOST_IN.rd_n) [*4];
  endsequence
  // Peer acknowledge held low against our own request
  sequence s_ack_on_req;
    (!REQUEST_OUT_N && !BUS_IN.acknowledge_in_n) [*3];
  endsequence
  sequence s_req_held;
    (!REQUEST_OUT_N && BUS_DATA_OE) ##1 !REQUEST_OUT_N;
  endsequence

  a_read_drives_data: assert property (s_read_low |-> DATA_OE)
    else $error("read strobe did not enable the data drivers");
  a_read_releases_data: assert property (s_read_off |-> !DATA_OE)
    else $error("data drivers kept on after the read ended");
  a_ack_follows_req: assert property ($fell(ACKNOWLEDGE_OUT_N) |-> !$past(BUS_IN.request_in_n, 3))
    else $error("acknowledge asserted without a request");
  a_ack_released: assert property (BUS_IN.request_in_n [*4] |-> ACKNOWLEDGE_OUT_N)
    else $error("acknowledge held after request rose");
  a_req_drops_ack: assert property (s_ack_on_req |=> REQUEST_OUT_N)
    else $error("request not released after acknowledge fell");
  a_req_after_ack: assert property ($fell(REQUEST_OUT_N) |-> $past(BUS_IN.acknowledge_in_n, 3))
    else $error("request asserted while acknowledge was low");
  a_data_leads_req: assert property ($fell(REQUEST_OUT_N) && BUS_DATA_OE |->
    $past(BUS_DATA_OE, 6) && BUS_DATA_OUT == $past(BUS_DATA_OUT, 6))
    else $error("data not set up before the request strobe");
  a_data_held_req: assert property (s_req_held |-> $stable(BUS_DATA_OUT))
    else $error("data changed under the request strobe");
  a_busrst_length: assert property ($fell(BUS_RESET_OUT) |-> rst_len_q == BUSRST_CYC)
    else $error("bus reset pulse has the wrong length");
endmodule // spc_core_properties

bind spc_core spc_core_properties u_props (
  .MCLK(MCLK),
  .RESETN(RESETN),
  .HOST_IN(HOST_IN),
  .DATA_OE(DATA_OE),
  .BUS_IN(BUS_IN),
  .BUS_DATA_OUT(BUS_DATA_OUT),
  .BUS_DATA_OE(BUS_DATA_OE),
  .REQUEST_OUT_N(REQUEST_OUT_N),
  .ACKNOWLEDGE_OUT_N(ACKNOWLEDGE_OUT_N),
  .BUS_RESET_OUT(BUS_RESET_OUT)
);

// >>> sim/spc_scsi_peer.sv
// Behavioural SCSI peer: initiator taking bytes, or target offering them
module spc_scsi_peer (
  // Clock
  input wire logic clk,
  // Device strobes and data
  input wire logic dev_req_n,
  input wire logic dev_ack_n,
  input wire logic [7:0] dev_data,
  // Peer drive
  output logic req_n,
  output logic ack_n,
  output logic [7:0] data,
  output logic par
);
  timeunit 1ns;
  timeprecision 1ps;
  // Odd parity over data and parity bit together
  assign par = ~^data;
  initial begin
    req_n = 1'b1;
    ack_n = 1'b1;
    data = 8'h5a;
  end
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  // As initiator: byte taken when the request is seen, acknowledge held until it rises
  task automatic take_byte(output logic [7:0] b, output bit ok);
    int i;
    for (i = 0; i < 100 && dev_req_n !== 1'b0; i++) step();
    ok = (dev_req_n === 1'b0);
    b = dev_data;
    ack_n = 1'b0;
    for (i = 0; i < 100 && dev_req_n !== 1'b1; i++) step();
    ok = ok && (dev_req_n === 1'b1);
    ack_n = 1'b1;
    step();
  endtask
  // As target: data settles six cycles ahead of the request; a released bus shows the inverse
  task automatic give_byte(input logic [7:0] b, output bit ok);
    int i;
    data = b;
    repeat (6) step();
    req_n = 1'b0;
    for (i = 0; i < 100 && dev_ack_n !== 1'b0; i++) step();
    ok = (dev_ack_n === 1'b0);
    req_n = 1'b1;
    data = ~b;
    for (i = 0; i < 100 && dev_ack_n !== 1'b1; i++) step();
    ok = ok && (dev_ack_n === 1'b1);
  endtask
endmodule // spc_scsi_peer

// >>> sim/spc_core_test.sv
// Self-checking bench for the protocol controller
module spc_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import spc_pkg::*;
  logic MCLK = 1'b0;
  logic RESETN = 1'b0;
  spc_host_t host;
  spc_bus_in_t bus_in;
  logic io_pin, oe, int_n, bus_oe, req_n, ack_n, atn_n, bus_rst, ctrl_oe, bus_par;
  logic p_req_n, p_ack_n, p_par;
  logic [7:0] dout, bus_data, p_data;
  logic [3:0] unmapped [5] = '{4'h9, 4'ha, 4'hd, 4'he, 4'hf};
  logic [7:0] misc_ops [7] = '{8'h00, 8'h80, 8'h01, 8'h81, 8'h12, 8'h92, 8'h1a};
  int errors = 0;
  int comparisons = 0;

  always #5 MCLK = ~MCLK;
  // Phase lines other than I/O idle high; bus reset line mirrors our own drive
  assign bus_in = '{request_in_n: p_req_n, acknowledge_in_n: p_ack_n, io: io_pin, cd: 1'b1,
    msg: 1'b1, rst_n: ~bus_rst, par: p_par, data: p_data};

  spc_core dut (.MCLK(MCLK), .RESETN(RESETN), .HOST_IN(host), .DATA_OUT(dout), .DATA_OE(oe),
    .INT_N(int_n), .BUS_IN(bus_in), .BUS_DATA_OUT(bus_data), .BUS_PARITY_OUT(bus_par),
    .BUS_DATA_OE(bus_oe), .REQUEST_OUT_N(req_n), .ACKNOWLEDGE_OUT_N(ack_n),
    .ATTENTION_OUT_N(atn_n), .BUS_RESET_OUT(bus_rst), .BUS_CTRL_OE(ctrl_oe));
  spc_scsi_peer peer (.clk(MCLK), .dev_req_n(req_n), .dev_ack_n(ack_n), .dev_data(bus_data),
    .req_n(p_req_n), .ack_n(p_ack_n), .data(p_data), .par(p_par));

  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic give_up(input string what);
    chk(what, 8'h01, 8'h00);
    wrap_up();
  endtask
  // Strobes held four cycles each way so the two-stage synchroniser sees both edges
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host = '{cs_n: 1'b0, rd_n: 1'b1, wr_n: 1'b0, addr: a, data: d};
    tick(4);
    host.wr_n = 1'b1;
    tick(4);
    host.cs_n = 1'b1;
    tick(4);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    int i;
    host = '{cs_n: 1'b0, rd_n: 1'b0, wr_n: 1'b1, addr: a, data: 8'h00};
    for (i = 0; i < 8 && oe !== 1'b1; i++) tick(1);
    if (oe !== 1'b1) give_up("read enable");
    tick(1);
    d = dout;
    host.cs_n = 1'b1;
    host.rd_n = 1'b1;
    for (i = 0; i < 8 && oe !== 1'b0; i++) tick(1);
    if (oe !== 1'b0) give_up("read release");
    tick(1);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk($sformatf("register %h", a), exp, d);
  endtask
  // Bus reset opcode: the pulse must end, then the cause shows unless muted
  task automatic bus_reset(input logic [7:0] op, input logic [7:0] irq);
    int i;
    wr(A_CMD, op);
    chk("bus reset out", 8'h01, 8'(bus_rst));
    for (i = 0; i < 3000 && bus_rst !== 1'b0; i++) tick(1);
    if (bus_rst !== 1'b0) give_up("bus reset end");
    tick(4);
    rdchk(A_IRQ, irq);
  endtask

  initial begin
    logic [7:0] v;
    bit ok;
    int k;
    host = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, data: 8'h00};
    io_pin = 1'b1;
    tick(2);
    RESETN = 1'b1;
    tick(2);
    chk("idle strobes", 8'h0f, 8'({int_n, req_n, ack_n, atn_n}));
    // Setup registers keep what was written; write-only and unlisted places read zero
    wr(A_SETUP1, 8'ha5);
    rdchk(A_SETUP1, 8'ha5);
    wr(A_SETUP2, 8'h5a);
    rdchk(A_SETUP2, 8'h5a);
    wr(A_SETUP3, 8'h07);
    rdchk(A_SETUP3, 8'h07);
    wr(A_CLKDIV, 8'hff);
    wr(A_RSVBYTE, 8'hff);
    foreach (unmapped[k]) rdchk(unmapped[k], 8'h00);
    // Test register is locked until the chip test bit opens it
    wr(A_TEST, 8'h04);
    chk("tri-state locked", 8'h01, 8'(ctrl_oe));
    wr(A_SETUP1, 8'had);
    wr(A_TEST, 8'h04);
    chk("tri-state", 8'h00, 8'(ctrl_oe));
    wr(A_TEST, 8'h00);
    wr(A_SETUP1, 8'ha5);
    // Unknown opcode raises the illegal cause; reading the causes clears them
    wr(A_CMD, 8'h3f);
    chk("interrupt line", 8'h00, 8'(int_n));
    rdchk(A_STAT, 8'h80);
    rdchk(A_IRQ, 8'h40);
    rdchk(A_IRQ, 8'h00);
    io_pin = 1'b0;
    rdchk(A_STAT, 8'h01);
    io_pin = 1'b1;
    // Every disconnected opcode, both forms: function complete at step four
    for (k = 0; k < 14; k++) begin
      wr(A_CMD, {k[0], 7'h40 + 7'(k / 2)});
      rdchk(A_SEQ, 8'h04);
      rdchk(A_IRQ, 8'h08);
    end
    foreach (misc_ops[k]) begin
      wr(A_CMD, misc_ops[k]);
      rd(A_IRQ, v);
      chk("illegal flag", 8'h00, 8'(v[6]));
    end
    chk("attention", 8'h00, 8'(atn_n));
    wr(A_CMD, 8'h82);
    chk("attention after reset", 8'h01, 8'(atn_n));
    wr(A_SETUP1, 8'ha5);
    bus_reset(8'h03, 8'h80);
    wr(A_SETUP1, 8'he5);
    bus_reset(8'h83, 8'h00);
    wr(A_SETUP1, 8'ha5);
    // Target send of two bytes; counter runs down to zero
    wr(A_CMD, 8'h01);
    wr(A_CNT_LO, 8'h02);
    wr(A_CNT_HI, 8'h00);
    wr(A_QUEUE, 8'h3c);
    wr(A_QUEUE, 8'hc3);
    wr(A_CMD, 8'h22);
    for (k = 0; k < 2; k++) begin
      peer.take_byte(v, ok);
      if (!ok) give_up("send handshake");
      chk("sent byte", k ? 8'hc3 : 8'h3c, v);
      // Both bytes hold four ones; parity test mode inverts the odd parity bit
      chk("sent parity", 8'h00, 8'(bus_par));
    end
    tick(4);
    chk("bus drivers", 8'h00, 8'(bus_oe));
    rdchk(A_STAT, 8'h98);
    rdchk(A_IRQ, 8'h10);
    rdchk(A_CNT_LO, 8'h00);
    rdchk(A_CNT_HI, 8'h00);
    // Initiator receive fills the queue; a host write then is refused
    io_pin = 1'b0;
    wr(A_CNT_LO, 8'h08);
    wr(A_CMD, 8'h10);
    for (k = 0; k < 8; k++) begin
      peer.give_byte(8'h10 + 8'(k), ok);
      if (!ok) give_up("receive handshake");
    end
    tick(4);
    rd(A_FLAGS, v);
    chk("queue level", 8'h08, 8'(v[3:0]));
    wr(A_QUEUE, 8'hee);
    rdchk(A_STAT, 8'hd9);
    rdchk(A_IRQ, 8'h10);
    // Queue is drained only once the transfer has ended
    for (k = 0; k < 8; k++) rdchk(A_QUEUE, 8'h10 + 8'(k));
    rd(A_FLAGS, v);
    chk("queue empty", 8'h00, 8'(v[3:0]));
    // Empty queue hands back the reserve byte once setup two enables it
    wr(A_RSVBYTE, 8'h6e);
    wr(A_SETUP2, 8'h80);
    rdchk(A_QUEUE, 8'h6e);
    io_pin = 1'b1;
    wrap_up();
  end
endmodule // spc_core_test
